//--- verilog/lpm_seq_pkg.sv
// constants, register layout and states of the low-power mode sequencer
package lpm_seq_pkg;
	// register byte addresses on the APB
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;

	// low_power_mode_control fields
	localparam int MODE_LSB      = 0;
	localparam int MODE_W        = 2;
	localparam int QUAL_LSB      = 2;
	localparam int QUAL_W        = 6;
	localparam int HALVING_BIT   = 8;
	localparam int CRYSTAL_BIT   = 9;
	localparam int WAKE_IE_BIT   = 10;
	localparam int FLASH_SLP_BIT = 11;
	localparam int CONTROL_W     = 12;
	localparam logic [CONTROL_W-1:0] CONTROL_RESET = 12'h000;

	// status fields
	localparam int STATE_LSB     = 0;
	localparam int STATE_W       = 4;
	localparam int WAKE_FLAG_BIT = 4;
	localparam int LOCKED_BIT    = 5;

	// low-power mode selections
	localparam logic [1:0] MODE_IDLE    = 2'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h1;
	localparam logic [1:0] MODE_HALT    = 2'h2;

	// timing figures, in cycles as printed
	localparam int DRAIN_SHORT_CYC    = 32;
	localparam int DRAIN_LONG_CYC     = 64;
	localparam int XCLK_LOW_MIN_CYC   = 32;
	localparam int XCLK_LOW_MAX_CYC   = 45;
	localparam int QUAL_BASE_CYC      = 2;
	localparam int IDLE_RESUME_CYC    = 20;
	localparam int STBY_FAST_MAX_CYC  = 100;
	localparam int FLASH_SLEEP_CYC    = 1125;
	localparam int HALT_RAM_MAX_CYC   = 35;
	localparam int PLL_LOCK_CYC       = 131072;
	localparam int SYNC_STAGES        = 2;
	// latency spent in the synchroniser and edge stage before counting
	localparam int SYNC_MARGIN_CYC    = SYNC_STAGES + 2;

	// counter width and derived loads
	localparam int CNT_W = 18;
	localparam logic [CNT_W-1:0] CNT_ZERO = 18'h0_0000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 18'h0_0001;
	localparam logic [CNT_W-1:0] DRAIN_SHORT = CNT_W'(DRAIN_SHORT_CYC);
	localparam logic [CNT_W-1:0] DRAIN_LONG  = CNT_W'(DRAIN_LONG_CYC);
	localparam logic [CNT_W-1:0] XCLK_LOW_AT = CNT_W'(XCLK_LOW_MIN_CYC);
	localparam logic [CNT_W-1:0] QUAL_BASE   = CNT_W'(QUAL_BASE_CYC);
	localparam logic [CNT_W-1:0] IDLE_RES =
		CNT_W'(IDLE_RESUME_CYC - SYNC_MARGIN_CYC);
	localparam logic [CNT_W-1:0] STBY_FAST_RES =
		CNT_W'(STBY_FAST_MAX_CYC - SYNC_MARGIN_CYC);
	localparam logic [CNT_W-1:0] FLASH_RES =
		CNT_W'(FLASH_SLEEP_CYC - SYNC_MARGIN_CYC);
	localparam logic [CNT_W-1:0] HALT_RAM_RES =
		CNT_W'(HALT_RAM_MAX_CYC - SYNC_MARGIN_CYC);

	typedef enum logic [STATE_W-1:0] {
		ST_RUN,
		ST_IDLE,
		ST_DRAIN,
		ST_STANDBY,
		ST_QUALIFY,
		ST_HALT,
		ST_OSC_WAKE,
		ST_PLL_LOCK,
		ST_RESUME
	} lpm_state_t;
endpackage

//--- verilog/low_power_mode_sequencer.sv
// low-power mode sequencer: IDLE/STANDBY/HALT entry, wake-up and APB regs
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps

// How it works
// - standby keeps system clock 32 or 64 cycles per halving, then stops it
// - standby gates peripheral clocks, keeps PLL and watchdog running
// - IDLE instruction with a mode selected enters that mode
// - external clock output goes low 32 to 45 cycles after IDLE in standby or halt
// - standby wake resumes within 100 cycles, 1125 from sleeping flash
// - after wake, execution resumes, interrupt serviced only if enabled
// - halt keeps system clock 32 or 64 cycles, then stops core, and osc with crystal source
// - halt stops peripherals and PLL, oscillator off with crystal source
// - falling wake pin edge restarts oscillator and begins halt wake-up
// - after oscillator stable, count PLL lock cycles before clocks on
// - halt wake resumes within 35 cycles, 1125 from sleeping flash
// - six-bit qualify count sets standby wake pulse to two plus it
module low_power_mode_sequencer #(
	parameter int PLL_LOCK_COUNT = lpm_seq_pkg::PLL_LOCK_CYC,
	parameter int OSC_START_CYC  = 16
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        idleExec,
	input  wire logic        wakeGpioPinN,
	input  wire logic        externalResetPinN,
	output logic             systemClockOutEnable,
	output logic             externalClockOutput,
	output logic             peripheralClockEnable,
	output logic             pllEnable,
	output logic             watchdogClockEnable,
	output logic             oscillatorEnable,
	output logic             coreClockEnable,
	output logic             execResume,
	output logic             wakeInterrupt
);
	localparam logic [lpm_seq_pkg::CNT_W-1:0] LOCK_LOAD =
		lpm_seq_pkg::CNT_W'(PLL_LOCK_COUNT);
	localparam logic [lpm_seq_pkg::CNT_W-1:0] OSC_LOAD =
		lpm_seq_pkg::CNT_W'(OSC_START_CYC);

	logic [lpm_seq_pkg::CONTROL_W-1:0] lowPowerModeControl;
	logic                              wakeFlag;
	lpm_seq_pkg::lpm_state_t           state;
	logic [lpm_seq_pkg::CNT_W-1:0]     count;
	logic [lpm_seq_pkg::CNT_W-1:0]     xclkCount;
	logic                              haltEntry;
	logic [1:0]                        wakeSync;
	logic [1:0]                        resetSync;
	logic                              wakeLowDly;
	logic                              resumeEvent;

	logic       apbWrite;
	logic       apbRead;
	logic [1:0] mode;
	logic [5:0] qualCount;
	logic       halving;
	logic       crystalSource;
	logic       wakeIntEnable;
	logic       flashAsleep;
	logic       wakeLow;
	logic       resetLow;
	logic       wakeFall;

	assign mode          = lowPowerModeControl[lpm_seq_pkg::MODE_LSB +:
		lpm_seq_pkg::MODE_W];
	assign qualCount     = lowPowerModeControl[lpm_seq_pkg::QUAL_LSB +:
		lpm_seq_pkg::QUAL_W];
	assign halving       = lowPowerModeControl[lpm_seq_pkg::HALVING_BIT];
	assign crystalSource = lowPowerModeControl[lpm_seq_pkg::CRYSTAL_BIT];
	assign wakeIntEnable = lowPowerModeControl[lpm_seq_pkg::WAKE_IE_BIT];
	assign flashAsleep   = lowPowerModeControl[lpm_seq_pkg::FLASH_SLP_BIT];
	assign wakeLow       = ~wakeSync[1];
	assign resetLow      = ~resetSync[1];
	assign wakeFall      = wakeLow & ~wakeLowDly;
	// writes land at the edge that completes the access, with pready high
	assign apbWrite      = psel & penable & pwrite & pready;
	assign apbRead       = psel & penable & ~pwrite & ~pready;

	// two-stage synchronisers for the pins; only stage two is used
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wakeSync  <= 2'h3;
			resetSync <= 2'h3;
		end else begin
			wakeSync  <= {wakeSync[0], wakeGpioPinN};
			resetSync <= {resetSync[0], externalResetPinN};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wakeLowDly <= 1'b0;
		end else begin
			wakeLowDly <= wakeLow;
		end
	end

	// control register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lowPowerModeControl <= lpm_seq_pkg::CONTROL_RESET;
		end else if (apbWrite && paddr == lpm_seq_pkg::ADDR_CONTROL) begin
			lowPowerModeControl <= pwdata[lpm_seq_pkg::CONTROL_W-1:0];
		end
	end

	// sticky wake flag, write one to clear; a new wake beats the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wakeFlag <= 1'b0;
		end else if (resumeEvent) begin
			wakeFlag <= 1'b1;
		end else if (apbWrite && paddr == lpm_seq_pkg::ADDR_STATUS &&
				pwdata[lpm_seq_pkg::WAKE_FLAG_BIT]) begin
			wakeFlag <= 1'b0;
		end
	end

	// APB answer: one wait state, unmapped addresses flag an error
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready &
				paddr != lpm_seq_pkg::ADDR_CONTROL &
				paddr != lpm_seq_pkg::ADDR_STATUS;
			if (apbRead) begin
				prdata <= 32'h0000_0000;
				if (paddr == lpm_seq_pkg::ADDR_CONTROL) begin
					prdata[lpm_seq_pkg::CONTROL_W-1:0] <= lowPowerModeControl;
				end else if (paddr == lpm_seq_pkg::ADDR_STATUS) begin
					prdata[lpm_seq_pkg::STATE_LSB +: lpm_seq_pkg::STATE_W]
						<= state;
					prdata[lpm_seq_pkg::WAKE_FLAG_BIT] <= wakeFlag;
					prdata[lpm_seq_pkg::LOCKED_BIT] <= pllEnable &
						state != lpm_seq_pkg::ST_PLL_LOCK;
				end
			end
		end
	end

	// sequencing state machine
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state     <= lpm_seq_pkg::ST_RUN;
			count     <= lpm_seq_pkg::CNT_ZERO;
			haltEntry <= 1'b0;
		end else begin
			unique case (state)
			lpm_seq_pkg::ST_RUN: begin
				if (idleExec) begin
					if (mode == lpm_seq_pkg::MODE_STANDBY ||
							mode == lpm_seq_pkg::MODE_HALT) begin
						state     <= lpm_seq_pkg::ST_DRAIN;
						haltEntry <= mode == lpm_seq_pkg::MODE_HALT;
						count     <= halving ? lpm_seq_pkg::DRAIN_LONG
							: lpm_seq_pkg::DRAIN_SHORT;
					end else begin
						// mode 3 is no low-power mode and falls back to IDLE
						state <= lpm_seq_pkg::ST_IDLE;
					end
				end
			end
			lpm_seq_pkg::ST_IDLE: begin
				// plain IDLE: any wake or reset level ends it
				if (wakeLow || resetLow) begin
					state <= lpm_seq_pkg::ST_RESUME;
					count <= lpm_seq_pkg::IDLE_RES;
				end
			end
			lpm_seq_pkg::ST_DRAIN: begin
				// clocks keep running so the pipeline can drain
				if (count == lpm_seq_pkg::CNT_ONE) begin
					state <= haltEntry ? lpm_seq_pkg::ST_HALT
						: lpm_seq_pkg::ST_STANDBY;
				end
				count <= count - lpm_seq_pkg::CNT_ONE;
			end
			lpm_seq_pkg::ST_STANDBY: begin
				// reset pin wakes at once; the wake pin passes the qualifier
				if (resetLow) begin
					state <= lpm_seq_pkg::ST_RESUME;
					count <= lpm_seq_pkg::STBY_FAST_RES;
				end else if (wakeFall) begin
					state <= lpm_seq_pkg::ST_QUALIFY;
					count <= lpm_seq_pkg::QUAL_BASE +
						lpm_seq_pkg::CNT_W'(qualCount);
				end
			end
			lpm_seq_pkg::ST_QUALIFY: begin
				// a pulse shorter than the qualify time drops back silently
				if (!wakeLow) begin
					state <= lpm_seq_pkg::ST_STANDBY;
				end else if (count == lpm_seq_pkg::CNT_ONE) begin
					state <= lpm_seq_pkg::ST_RESUME;
					count <= flashAsleep ? lpm_seq_pkg::FLASH_RES
						: lpm_seq_pkg::STBY_FAST_RES;
				end else begin
					count <= count - lpm_seq_pkg::CNT_ONE;
				end
			end
			lpm_seq_pkg::ST_HALT: begin
				if (wakeFall || resetLow) begin
					state <= lpm_seq_pkg::ST_OSC_WAKE;
					count <= OSC_LOAD;
				end
			end
			lpm_seq_pkg::ST_OSC_WAKE: begin
				// stable once the start time passed and the pins are released
				if (count != lpm_seq_pkg::CNT_ZERO) begin
					count <= count - lpm_seq_pkg::CNT_ONE;
				end else if (!wakeLow && !resetLow) begin
					state <= lpm_seq_pkg::ST_PLL_LOCK;
					count <= LOCK_LOAD;
				end
			end
			lpm_seq_pkg::ST_PLL_LOCK: begin
				// lock count runs in full on every halt wake, with no early exit
				if (count == lpm_seq_pkg::CNT_ONE) begin
					state <= lpm_seq_pkg::ST_RESUME;
					count <= flashAsleep ? lpm_seq_pkg::FLASH_RES
						: lpm_seq_pkg::HALT_RAM_RES;
				end else begin
					count <= count - lpm_seq_pkg::CNT_ONE;
				end
			end
			lpm_seq_pkg::ST_RESUME: begin
				// strobe follows one cycle after the count runs out
				if (count <= lpm_seq_pkg::CNT_ONE) begin
					state <= lpm_seq_pkg::ST_RUN;
				end
				count <= count - lpm_seq_pkg::CNT_ONE;
			end
			default: begin
				state <= lpm_seq_pkg::ST_RUN;
			end
			endcase
		end
	end

	// one registered event drives both the strobe and the sticky flag
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			resumeEvent <= 1'b0;
		end else begin
			resumeEvent <= state == lpm_seq_pkg::ST_RESUME &&
				count <= lpm_seq_pkg::CNT_ONE;
		end
	end

	// resume strobe, interrupt request only when enabled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			execResume    <= 1'b0;
			wakeInterrupt <= 1'b0;
		end else begin
			execResume    <= resumeEvent;
			wakeInterrupt <= resumeEvent & wakeIntEnable;
		end
	end

	// external clock output drops a fixed delay after IDLE into standby or halt
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			xclkCount           <= lpm_seq_pkg::CNT_ZERO;
			externalClockOutput <= 1'b1;
		end else if (state == lpm_seq_pkg::ST_RUN && idleExec &&
				(mode == lpm_seq_pkg::MODE_STANDBY ||
				mode == lpm_seq_pkg::MODE_HALT)) begin
			xclkCount <= lpm_seq_pkg::XCLK_LOW_AT - lpm_seq_pkg::CNT_ONE;
		end else if (xclkCount != lpm_seq_pkg::CNT_ZERO) begin
			xclkCount <= xclkCount - lpm_seq_pkg::CNT_ONE;
			if (xclkCount == lpm_seq_pkg::CNT_ONE) begin
				externalClockOutput <= 1'b0;
			end
			// back high once the sequencer heads for RUN
		end else if (state == lpm_seq_pkg::ST_RESUME ||
				state == lpm_seq_pkg::ST_RUN) begin
			externalClockOutput <= 1'b1;
		end
	end

	// clock gate controls
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			systemClockOutEnable  <= 1'b1;
			peripheralClockEnable <= 1'b1;
			pllEnable             <= 1'b1;
			watchdogClockEnable   <= 1'b1;
			oscillatorEnable      <= 1'b1;
			coreClockEnable       <= 1'b1;
		end else begin
			unique case (state)
			lpm_seq_pkg::ST_STANDBY, lpm_seq_pkg::ST_QUALIFY: begin
				systemClockOutEnable  <= 1'b0;
				peripheralClockEnable <= 1'b0;
				pllEnable             <= 1'b1;
				watchdogClockEnable   <= 1'b1;
				oscillatorEnable      <= 1'b1;
				coreClockEnable       <= 1'b0;
			end
			lpm_seq_pkg::ST_HALT: begin
				systemClockOutEnable  <= 1'b0;
				peripheralClockEnable <= 1'b0;
				pllEnable             <= 1'b0;
				watchdogClockEnable   <= 1'b0;
				// an external clock source keeps the oscillator running
				oscillatorEnable      <= ~crystalSource;
				coreClockEnable       <= 1'b0;
			end
			lpm_seq_pkg::ST_OSC_WAKE, lpm_seq_pkg::ST_PLL_LOCK: begin
				systemClockOutEnable  <= 1'b0;
				peripheralClockEnable <= 1'b0;
				pllEnable             <= 1'b1;
				watchdogClockEnable   <= 1'b0;
				oscillatorEnable      <= 1'b1;
				coreClockEnable       <= 1'b0;
			end
			default: begin
				systemClockOutEnable  <= 1'b1;
				peripheralClockEnable <= 1'b1;
				pllEnable             <= 1'b1;
				watchdogClockEnable   <= 1'b1;
				oscillatorEnable      <= 1'b1;
				coreClockEnable       <= 1'b1;
			end
			endcase
		end
	end
endmodule

//--- testbench/lpm_seq_monitor.sv
// port-level assertion checker for the low-power mode sequencer
`timescale 1ns/1ps
module lpm_seq_monitor #(
	parameter int PLL_LOCK_COUNT = 64,
	parameter int OSC_START_CYC  = 4
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        idleExec,
	input wire logic        wakeGpioPinN,
	input wire logic        externalResetPinN,
	input wire logic        systemClockOutEnable,
	input wire logic        externalClockOutput,
	input wire logic        peripheralClockEnable,
	input wire logic        pllEnable,
	input wire logic        watchdogClockEnable,
	input wire logic        oscillatorEnable,
	input wire logic        execResume,
	input wire logic        wakeInterrupt
);
	logic [11:0] ctl;
	logic [15:0] since;
	logic        busy, prevG, prevR, stby, halt, entr;
	int          stbyMax, haltMax;
	assign stby = ctl[1:0] == lpm_seq_pkg::MODE_STANDBY;
	assign halt = ctl[1:0] == lpm_seq_pkg::MODE_HALT;
	assign entr = idleExec && !busy && (stby || halt);
	assign stbyMax = (ctl[11] ? 1125 : 100) + 2 + int'(ctl[7:2]);
	assign haltMax = PLL_LOCK_COUNT + (ctl[11] ? 1125 : 35) + 4;
	// control shadow, busy from idle entry to resume, cycles since pin change
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctl <= 12'h000;
			busy <= 1'b0;
			since <= 16'h0000;
			prevG <= 1'b1;
			prevR <= 1'b1;
		end else begin
			if (psel && penable && pwrite && pready && paddr == 8'h00)
				ctl <= pwdata[11:0];
			busy <= execResume ? 1'b0 : (idleExec ? 1'b1 : busy);
			prevG <= wakeGpioPinN;
			prevR <= externalResetPinN;
			if (wakeGpioPinN != prevG || externalResetPinN != prevR)
				since <= 16'h0000;
			else
				since <= since + 16'h0001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_hold32; ##31 systemClockOutEnable ##[1:6] !systemClockOutEnable;
	endsequence
	sequence s_hold64; ##63 systemClockOutEnable ##[1:6] !systemClockOutEnable;
	endsequence
	sequence s_xlow; ##31 externalClockOutput ##[1:14] !externalClockOutput;
	endsequence
	property p_drain32; entr && !ctl[8] |-> s_hold32; endproperty
	a_drain32: assert property (p_drain32)
		else $error("system clock not held 32 cycles");
	property p_drain64; entr && ctl[8] |-> s_hold64; endproperty
	a_drain64: assert property (p_drain64)
		else $error("system clock not held 64 cycles");
	property p_xclk; entr |-> s_xlow; endproperty
	a_xclk: assert property (p_xclk)
		else $error("external clock low outside 32 to 45 cycles");
	property p_stbyGate; busy && stby && !systemClockOutEnable |->
		!peripheralClockEnable && pllEnable && watchdogClockEnable; endproperty
	a_stbyGate: assert property (p_stbyGate)
		else $error("standby clock gating wrong");
	property p_haltGate; $fell(systemClockOutEnable) && halt |-> ##[0:1]
		(!pllEnable && !peripheralClockEnable && oscillatorEnable == !ctl[9]);
	endproperty
	a_haltGate: assert property (p_haltGate)
		else $error("halt clock gating wrong");
	property p_oscWake; halt && !oscillatorEnable && $fell(wakeGpioPinN) |->
		##[1:6] oscillatorEnable; endproperty
	a_oscWake: assert property (p_oscWake)
		else $error("oscillator not restarted by wake pin");
	property p_stbyRes; execResume && busy && stby |-> since <= stbyMax;
	endproperty
	a_stbyRes: assert property (p_stbyRes)
		else $error("standby resume too late");
	property p_pllLock; execResume && busy && halt |-> since >= PLL_LOCK_COUNT;
	endproperty
	a_pllLock: assert property (p_pllLock)
		else $error("resume before pll lock count");
	property p_haltRes; execResume && busy && halt |-> since <= haltMax;
	endproperty
	a_haltRes: assert property (p_haltRes)
		else $error("halt resume too late");
	property p_irq; execResume || wakeInterrupt |->
		wakeInterrupt == (execResume && ctl[10]); endproperty
	a_irq: assert property (p_irq)
		else $error("wake interrupt not tied to enabled resume");
endmodule
bind low_power_mode_sequencer lpm_seq_monitor #(
	.PLL_LOCK_COUNT(PLL_LOCK_COUNT),
	.OSC_START_CYC(OSC_START_CYC)
) u_lpm_seq_monitor (.*);

//--- testbench/wake_source.sv
// external wake source driving the wake or the reset pin low for a set time
`timescale 1ns/1ps
module wake_source (
	input  wire logic        sys_clk,
	input  wire logic        go,
	input  wire logic        useReset,
	input  wire logic [11:0] lowCycles,
	output logic             wakeGpioPinN,
	output logic             externalResetPinN
);
	logic [11:0] left = 12'h000;
	always @(posedge sys_clk) begin
		if (go)
			left <= lowCycles;
		else if (left != 12'h000)
			left <= left - 12'h001;
	end
	// pins are pulled up; held low for the full time before release
	assign wakeGpioPinN = !(left != 12'h000 && !useReset);
	assign externalResetPinN = !(left != 12'h000 && useReset);
endmodule

//--- testbench/testbench.sv
// directed bench for the low-power mode sequencer
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin \
	errTotal++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
	localparam int PLL_N = 64;
	localparam int OSC_N = 4;
	localparam logic [7:0] A_C = lpm_seq_pkg::ADDR_CONTROL;
	localparam logic [7:0] A_S = lpm_seq_pkg::ADDR_STATUS;
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic        idleExec, wakeGpioPinN, externalResetPinN, execResume;
	logic        systemClockOutEnable, externalClockOutput, pllEnable;
	logic        peripheralClockEnable, watchdogClockEnable, wakeInterrupt;
	logic        oscillatorEnable, coreClockEnable, go, useReset;
	logic [7:0]  paddr;
	logic [11:0] lowCycles;
	logic [31:0] pwdata, prdata, q;
	int          errTotal, nChecks, cycles;
	low_power_mode_sequencer #(.PLL_LOCK_COUNT(PLL_N), .OSC_START_CYC(OSC_N))
		u_low_power_mode_sequencer (.*);
	wake_source u_wake_source (.*);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		`CHECK("pready", 1'b1, pready)
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdChk(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] ex, input logic ee);
		xfer(a, 1'b0, 32'h0000_0000);
		`CHECK(nm, ex, q & m)
		`CHECK(nm, ee, e)
	endtask
	task automatic enter(input logic [31:0] c);
		xfer(A_C, 1'b1, c);
		@(posedge sys_clk);
		idleExec <= 1'b1;
		@(posedge sys_clk);
		idleExec <= 1'b0;
		repeat (40) @(posedge sys_clk);
	endtask
	task automatic wake(input logic r, input logic [11:0] n);
		@(posedge sys_clk);
		go <= 1'b1;
		useReset <= r;
		lowCycles <= n;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask
	task automatic resume(input logic ex);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (execResume !== 1'b1 && n < 3000);
		`CHECK("execResume", 1'b1, execResume)
		`CHECK("wakeInterrupt", ex, wakeInterrupt)
	endtask
	task automatic testRegs();
		rdChk("ctlReset", A_C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		rdChk("status", A_S, 32'h0000_001F, 32'h0000_0000, 1'b0);
		xfer(8'h08, 1'b1, 32'hFFFF_FFFF);
		rdChk("unmapped", 8'h08, 32'hFFFF_FFFF, 32'h0, 1'b1);
		xfer(A_C, 1'b1, 32'hFFFF_F0FC);
		rdChk("ctlWrite", A_C, 32'hFFFF_FFFF, 32'h0000_00FC, 1'b0);
	endtask
	task automatic testIdle();
		enter(32'h0000_0000);
		rdChk("idleSt", A_S, 32'h0000_000F, 32'h0000_0001, 1'b0);
		wake(1'b1, 12'h014);
		resume(1'b0);
		repeat (20) @(posedge sys_clk);
	endtask
	task automatic testStandby();
		enter(32'h0000_040D);
		`CHECK("sysClk", 1'b0, systemClockOutEnable)
		`CHECK("periph", 1'b0, peripheralClockEnable)
		`CHECK("pll", 1'b1, pllEnable)
		`CHECK("wdog", 1'b1, watchdogClockEnable)
		`CHECK("xclkLow", 1'b0, externalClockOutput)
		wake(1'b0, 12'h003);
		repeat (150) @(posedge sys_clk);
		rdChk("qualShort", A_S, 32'h0000_002F, 32'h0000_0023, 1'b0);
		wake(1'b0, 12'h0C8);
		resume(1'b1);
		`CHECK("xclkHigh", 1'b1, externalClockOutput)
		repeat (200) @(posedge sys_clk);
		enter(32'h0000_0001);
		wake(1'b1, 12'h00A);
		resume(1'b0);
	endtask
	task automatic testStandbyLong();
		enter(32'h0000_0901);
		`CHECK("sysClk64", 1'b1, systemClockOutEnable)
		repeat (30) @(posedge sys_clk);
		`CHECK("sysClkOff", 1'b0, systemClockOutEnable)
		wake(1'b0, 12'h514);
		resume(1'b0);
		repeat (1300) @(posedge sys_clk);
	endtask
	task automatic testHalt();
		xfer(A_S, 1'b1, 32'h0000_0010);
		enter(32'h0000_0602);
		`CHECK("osc", 1'b0, oscillatorEnable)
		`CHECK("pllOff", 1'b0, pllEnable)
		`CHECK("periphOff", 1'b0, peripheralClockEnable)
		`CHECK("core", 1'b0, coreClockEnable)
		wake(1'b0, 12'(OSC_N + 2));
		resume(1'b1);
		rdChk("flag", A_S, 32'h0000_0010, 32'h0000_0010, 1'b0);
		xfer(A_S, 1'b1, 32'h0000_0010);
		rdChk("flagClr", A_S, 32'h0000_0010, 32'h0000_0000, 1'b0);
	endtask
	task automatic testHaltRst();
		enter(32'h0000_0802);
		`CHECK("oscOn", 1'b1, oscillatorEnable)
		`CHECK("pllHalt", 1'b0, pllEnable)
		wake(1'b1, 12'(OSC_N + 8));
		resume(1'b0);
	endtask
	task automatic printVerdict();
		$display("checks %0d errors %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			errTotal++;
			printVerdict();
		end
	end
	initial begin
		errTotal = 0;
		nChecks = 0;
		cycles = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		idleExec = 1'b0;
		go = 1'b0;
		useReset = 1'b0;
		lowCycles = 12'h000;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		testRegs();
		testIdle();
		testStandby();
		testStandbyLong();
		testHalt();
		testHaltRst();
		printVerdict();
	end
endmodule
